// >>> cie_pkg.sv
// Constants, encodings and register map for the interrupt entry block.
// Assumes a 32-bit core on one clock with registers reached over AXI4-Lite.
package cie_pkg;
  localparam int unsigned AW = 8;
  // Register byte offsets
  localparam logic [AW-1:0] OFF_MSTATUS = 8'h00;
  localparam logic [AW-1:0] OFF_MEPC    = 8'h04;
  localparam logic [AW-1:0] OFF_MCAUSE  = 8'h08;
  localparam logic [AW-1:0] OFF_MTVEC   = 8'h0c;
  localparam logic [AW-1:0] OFF_MTVT    = 8'h10;
  localparam logic [AW-1:0] OFF_LEVEL   = 8'h14;
  localparam logic [AW-1:0] OFF_SUBMODE = 8'h18;
  localparam logic [AW-1:0] OFF_PRIV    = 8'h1c;
  // Field positions
  localparam int MIE_BIT        = 3;
  localparam int MPIE_BIT       = 7;
  localparam int MPP_LSB        = 11;
  localparam int CAUSE_PIL_LSB  = 16;
  localparam int CAUSE_MPIE_BIT = 27;
  localparam int CAUSE_MPP_LSB  = 28;
  localparam int CAUSE_HV_BIT   = 30;
  localparam int CAUSE_INT_BIT  = 31;
  localparam int LEVEL_LSB      = 24;
  localparam int SUBM_NOW_LSB   = 6;
  localparam int SUBM_PRIOR_LSB = 8;
  localparam int MTVEC_ALIGN    = 6;
  // Encodings
  localparam logic [1:0] PRIV_M         = 2'h3;
  localparam logic [1:0] PRIV_U         = 2'h0;
  localparam logic [1:0] MTVEC_MODE_LOC = 2'h3;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;
  // Reset values
  localparam logic [1:0]  RST_PRIV  = PRIV_M;
  localparam logic [31:0] RST_MTVEC = 32'h0000_0000;
  typedef enum logic [1:0] {
    SUBM_NORMAL = 2'h0,
    SUBM_INT    = 2'h1,
    SUBM_EXC    = 2'h2,
    SUBM_NMI    = 2'h3
  } cie_subm_t;
  typedef enum logic [0:0] {
    FS_IDLE  = 1'h0,
    FS_FETCH = 1'h1
  } cie_fetch_t;
endpackage : cie_pkg

// >>> cie_csr_if.sv
// Register access path between the bus slave and the register file.
// Assumes one clock; strobes are single-cycle and read data is combinational.
interface cie_csr_if;
  logic          wr_en;
  logic [7:0]    wr_addr;
  logic [31:0]   wr_data;
  logic [3:0]    wr_strb;
  logic          wr_ok;
  logic [7:0]    rd_addr;
  logic [31:0]   rd_data;
  logic          rd_ok;
  modport slv  (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                input wr_ok, rd_data, rd_ok);
  modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                output wr_ok, rd_data, rd_ok);
endinterface : cie_csr_if

// >>> cie_axil_slave.sv
// AXI4-Lite slave that turns bus transfers into register strobes.
// Assumes the register side answers reads and decodes combinationally.
module cie_axil_slave
  import cie_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  ce,
  input  wire logic [cie_pkg::AW-1:0] s_axil_awaddr,
  input  wire logic                  s_axil_awvalid,
  output logic                       s_axil_awready,
  input  wire logic [31:0]           s_axil_wdata,
  input  wire logic [3:0]            s_axil_wstrb,
  input  wire logic                  s_axil_wvalid,
  output logic                       s_axil_wready,
  output logic [1:0]                 s_axil_bresp,
  output logic                       s_axil_bvalid,
  input  wire logic                  s_axil_bready,
  input  wire logic [cie_pkg::AW-1:0] s_axil_araddr,
  input  wire logic                  s_axil_arvalid,
  output logic                       s_axil_arready,
  output logic [31:0]                s_axil_rdata,
  output logic [1:0]                 s_axil_rresp,
  output logic                       s_axil_rvalid,
  input  wire logic                  s_axil_rready,
  cie_csr_if.slv                     csr
);
  typedef struct packed {
    logic          awh;
    logic [AW-1:0] awaddr;
    logic          wh;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    logic          aw_rdy;
    logic          w_rdy;
    logic          ar_rdy;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          rvalid;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
  } cie_slv_st_t;

  cie_slv_st_t st_ff;
  cie_slv_st_t nxt_st;

  // Write fires once both halves are held, so address and data may come in either order
  assign csr.wr_en   = st_ff.awh && st_ff.wh && !st_ff.bvalid;
  assign csr.wr_addr = st_ff.awaddr;
  assign csr.wr_data = st_ff.wdata;
  assign csr.wr_strb = st_ff.wstrb;
  assign csr.rd_addr = s_axil_araddr;

  always_comb begin
    nxt_st = st_ff;
    if (s_axil_awvalid && st_ff.aw_rdy) begin
      nxt_st.awh    = 1'b1;
      nxt_st.awaddr = s_axil_awaddr;
    end
    if (s_axil_wvalid && st_ff.w_rdy) begin
      nxt_st.wh    = 1'b1;
      nxt_st.wdata = s_axil_wdata;
      nxt_st.wstrb = s_axil_wstrb;
    end
    if (st_ff.bvalid && s_axil_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (csr.wr_en) begin
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = csr.wr_ok ? RESP_OKAY : RESP_SLVERR;
      nxt_st.awh    = 1'b0;
      nxt_st.wh     = 1'b0;
    end
    if (st_ff.rvalid && s_axil_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axil_arvalid && st_ff.ar_rdy) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata  = csr.rd_ok ? csr.rd_data : 32'h0000_0000;
      nxt_st.rresp  = csr.rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    nxt_st.aw_rdy = !nxt_st.awh && !nxt_st.bvalid;
    nxt_st.w_rdy  = !nxt_st.wh && !nxt_st.bvalid;
    nxt_st.ar_rdy = !nxt_st.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign s_axil_awready = st_ff.aw_rdy;
  assign s_axil_wready  = st_ff.w_rdy;
  assign s_axil_bvalid  = st_ff.bvalid;
  assign s_axil_bresp   = st_ff.bresp;
  assign s_axil_arready = st_ff.ar_rdy;
  assign s_axil_rvalid  = st_ff.rvalid;
  assign s_axil_rdata   = st_ff.rdata;
  assign s_axil_rresp   = st_ff.rresp;
endmodule : cie_axil_slave

// >>> cie_preempt_gate.sv
// Decides whether the offered controller interrupt may be taken now.
// Assumes the controller already offers its single best candidate.
module cie_preempt_gate (
  input  wire logic       loc_mode,
  input  wire logic       mie,
  input  wire logic       busy,
  input  wire logic       irq_valid,
  input  wire logic [7:0] irq_level,
  input  wire logic [7:0] active_int_level,
  output logic            take
);
  logic level_ok;

  // A nested interrupt must outrank the one in service; equal levels wait
  assign level_ok = (active_int_level == 8'h00) || (irq_level > active_int_level);
  assign take     = loc_mode && mie && !busy && irq_valid && level_ok;
endmodule : cie_preempt_gate

// >>> cie_int_entry.sv
// Interrupt entry and return state for the local-controller mode of the core.
// Assumes core-side inputs share aclk; vector table words arrive on the vec_rsp port.
module cie_int_entry
  import cie_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  ce,
  input  wire logic [cie_pkg::AW-1:0] s_axil_awaddr,
  input  wire logic                  s_axil_awvalid,
  output logic                       s_axil_awready,
  input  wire logic [31:0]           s_axil_wdata,
  input  wire logic [3:0]            s_axil_wstrb,
  input  wire logic                  s_axil_wvalid,
  output logic                       s_axil_wready,
  output logic [1:0]                 s_axil_bresp,
  output logic                       s_axil_bvalid,
  input  wire logic                  s_axil_bready,
  input  wire logic [cie_pkg::AW-1:0] s_axil_araddr,
  input  wire logic                  s_axil_arvalid,
  output logic                       s_axil_arready,
  output logic [31:0]                s_axil_rdata,
  output logic [1:0]                 s_axil_rresp,
  output logic                       s_axil_rvalid,
  input  wire logic                  s_axil_rready,
  input  wire logic                  irq_valid,
  input  wire logic [11:0]           irq_id,
  input  wire logic [7:0]            irq_level,
  input  wire logic                  irq_shv,
  output logic                       irq_ack,
  input  wire logic [31:0]           cur_pc,
  input  wire logic                  mret_req,
  output logic                       redirect_valid,
  output logic [31:0]                redirect_pc,
  output logic                       vec_req,
  output logic [31:0]                vec_addr,
  input  wire logic                  vec_rsp_valid,
  input  wire logic [31:0]           vec_rsp_data,
  input  wire logic                  vec_rsp_err,
  output logic                       iaf_exc,
  output logic [1:0]                 priv_mode,
  output logic [1:0]                 machine_submode_now,
  output logic [7:0]                 active_int_level
);
  import cie_pkg::*;

  typedef struct packed {
    logic [31:0] mstatus;
    logic [31:0] mepc;
    logic [11:0] exccode;
    logic        cause_int;
    logic        minhv;
    logic [7:0]  prior_int_level;
    logic [31:0] mtvec;
    logic [31:0] mtvt;
    logic [7:0]  act_lvl;
    cie_subm_t   subm_now;
    cie_subm_t   machine_submode_prior;
    logic [1:0]  priv;
    cie_fetch_t  fst;
    logic        vreq;
    logic [31:0] vaddr;
    logic        ack;
    logic        redir_v;
    logic [31:0] redir_pc;
    logic        iaf;
  } cie_core_st_t;

  localparam logic [31:0] MSTATUS_WMASK = 32'h0000_1888;

  cie_core_st_t st_ff;
  cie_core_st_t nxt_st;
  cie_csr_if    csr ();
  logic         take;
  logic         loc_mode;
  logic [31:0]  cause_view;
  logic [31:0]  cause_wr;
  logic [31:0]  mepc_q;

  function automatic logic [31:0] wmerge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : wmerge

  cie_axil_slave u_slave (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .ce             (ce),
    .s_axil_awaddr  (s_axil_awaddr),
    .s_axil_awvalid (s_axil_awvalid),
    .s_axil_awready (s_axil_awready),
    .s_axil_wdata   (s_axil_wdata),
    .s_axil_wstrb   (s_axil_wstrb),
    .s_axil_wvalid  (s_axil_wvalid),
    .s_axil_wready  (s_axil_wready),
    .s_axil_bresp   (s_axil_bresp),
    .s_axil_bvalid  (s_axil_bvalid),
    .s_axil_bready  (s_axil_bready),
    .s_axil_araddr  (s_axil_araddr),
    .s_axil_arvalid (s_axil_arvalid),
    .s_axil_arready (s_axil_arready),
    .s_axil_rdata   (s_axil_rdata),
    .s_axil_rresp   (s_axil_rresp),
    .s_axil_rvalid  (s_axil_rvalid),
    .s_axil_rready  (s_axil_rready),
    .csr            (csr.slv)
  );

  assign loc_mode = (st_ff.mtvec[1:0] == MTVEC_MODE_LOC);

  // The gate relies on the controller already offering its best source
  cie_preempt_gate u_gate (
    .loc_mode         (loc_mode),
    .mie              (st_ff.mstatus[MIE_BIT]),
    .busy             ((st_ff.fst != FS_IDLE) || mret_req),
    .irq_valid        (irq_valid),
    .irq_level        (irq_level),
    .active_int_level (st_ff.act_lvl),
    .take             (take)
  );

  // Previous enable and privilege live only in mstatus, so both views agree
  assign cause_view = {st_ff.cause_int, st_ff.minhv, st_ff.mstatus[MPP_LSB +: 2],
                       st_ff.mstatus[MPIE_BIT], 3'h0, st_ff.prior_int_level, 4'h0,
                       st_ff.exccode};
  assign cause_wr   = wmerge(cause_view, csr.wr_data, csr.wr_strb);

  always_comb begin
    csr.rd_ok   = 1'b1;
    csr.rd_data = 32'h0000_0000;
    if (csr.rd_addr == OFF_MSTATUS) begin
      csr.rd_data = st_ff.mstatus;
    end else if (csr.rd_addr == OFF_MEPC) begin
      csr.rd_data = st_ff.mepc;
    end else if (csr.rd_addr == OFF_MCAUSE) begin
      csr.rd_data = cause_view;
    end else if (csr.rd_addr == OFF_MTVEC) begin
      csr.rd_data = st_ff.mtvec;
    end else if (csr.rd_addr == OFF_MTVT) begin
      csr.rd_data = st_ff.mtvt;
    end else if (csr.rd_addr == OFF_LEVEL) begin
      csr.rd_data = {st_ff.act_lvl, 24'h00_0000};
    end else if (csr.rd_addr == OFF_SUBMODE) begin
      csr.rd_data = {22'h00_0000, st_ff.machine_submode_prior, st_ff.subm_now, 6'h00};
    end else if (csr.rd_addr == OFF_PRIV) begin
      csr.rd_data = {30'h0000_0000, st_ff.priv};
    end else begin
      csr.rd_ok = 1'b0;
    end
  end

  // Level, sub-mode now and privilege ignore software writes, which are still answered OKAY
  assign csr.wr_ok = (csr.wr_addr == OFF_MSTATUS) || (csr.wr_addr == OFF_MEPC)
                  || (csr.wr_addr == OFF_MCAUSE)  || (csr.wr_addr == OFF_MTVEC)
                  || (csr.wr_addr == OFF_MTVT)    || (csr.wr_addr == OFF_LEVEL)
                  || (csr.wr_addr == OFF_SUBMODE) || (csr.wr_addr == OFF_PRIV);

  always_comb begin
    nxt_st         = st_ff;
    nxt_st.ack     = 1'b0;
    nxt_st.redir_v = 1'b0;
    nxt_st.iaf     = 1'b0;
    // Software first, so a same-cycle hardware event overrides it
    if (csr.wr_en) begin
      if (csr.wr_addr == OFF_MSTATUS) begin
        nxt_st.mstatus = wmerge(st_ff.mstatus, csr.wr_data, csr.wr_strb) & MSTATUS_WMASK;
      end else if (csr.wr_addr == OFF_MEPC) begin
        nxt_st.mepc = wmerge(st_ff.mepc, csr.wr_data, csr.wr_strb);
      end else if (csr.wr_addr == OFF_MCAUSE) begin
        nxt_st.cause_int                = cause_wr[CAUSE_INT_BIT];
        nxt_st.minhv                    = cause_wr[CAUSE_HV_BIT];
        nxt_st.mstatus[MPP_LSB +: 2]    = cause_wr[CAUSE_MPP_LSB +: 2];
        nxt_st.mstatus[MPIE_BIT]        = cause_wr[CAUSE_MPIE_BIT];
        nxt_st.prior_int_level          = cause_wr[CAUSE_PIL_LSB +: 8];
        nxt_st.exccode                  = cause_wr[11:0];
      end else if (csr.wr_addr == OFF_MTVEC) begin
        nxt_st.mtvec = wmerge(st_ff.mtvec, csr.wr_data, csr.wr_strb);
      end else if (csr.wr_addr == OFF_MTVT) begin
        nxt_st.mtvt = wmerge(st_ff.mtvt, csr.wr_data, csr.wr_strb);
      end else if (csr.wr_addr == OFF_SUBMODE) begin
        nxt_st.machine_submode_prior = csr.wr_strb[1]
          ? cie_subm_t'(csr.wr_data[SUBM_PRIOR_LSB +: 2])
          : st_ff.machine_submode_prior;
      end
    end
    case (st_ff.fst)
      FS_IDLE: begin
        if (mret_req) begin
          nxt_st.mstatus[MIE_BIT]     = st_ff.mstatus[MPIE_BIT];
          nxt_st.mstatus[MPIE_BIT]    = 1'b1;
          nxt_st.priv                 = st_ff.mstatus[MPP_LSB +: 2];
          nxt_st.mstatus[MPP_LSB +: 2] = PRIV_U;
          nxt_st.redir_v              = 1'b1;
          nxt_st.redir_pc             = st_ff.mepc;
          if (loc_mode) begin
            nxt_st.act_lvl  = st_ff.prior_int_level;
            nxt_st.subm_now = st_ff.machine_submode_prior;
          end
        end else if (take) begin
          // Every entry effect lands on the same edge
          nxt_st.ack                   = 1'b1;
          nxt_st.mepc                  = cur_pc;
          nxt_st.exccode               = irq_id;
          nxt_st.cause_int             = 1'b1;
          nxt_st.mstatus[MPIE_BIT]     = st_ff.mstatus[MIE_BIT];
          nxt_st.mstatus[MIE_BIT]      = 1'b0;
          nxt_st.mstatus[MPP_LSB +: 2] = st_ff.priv;
          nxt_st.priv                  = PRIV_M;
          nxt_st.machine_submode_prior = st_ff.subm_now;
          nxt_st.subm_now              = SUBM_INT;
          nxt_st.prior_int_level       = st_ff.act_lvl;
          nxt_st.act_lvl               = irq_level;
          if (irq_shv) begin
            // Branch waits for the table word
            nxt_st.minhv = 1'b1;
            nxt_st.fst   = FS_FETCH;
            nxt_st.vreq  = 1'b1;
            nxt_st.vaddr = st_ff.mtvt + {18'h0_0000, irq_id, 2'h0};
          end else begin
            nxt_st.redir_v  = 1'b1;
            nxt_st.redir_pc = {st_ff.mtvec[31:MTVEC_ALIGN], 6'h00};
          end
        end
      end
      FS_FETCH: begin
        if (vec_rsp_valid) begin
          nxt_st.fst  = FS_IDLE;
          nxt_st.vreq = 1'b0;
          if (vec_rsp_err) begin
            // minhv stays set so the fault handler can see the cause
            nxt_st.iaf = 1'b1;
          end else begin
            nxt_st.minhv    = 1'b0;
            nxt_st.redir_v  = 1'b1;
            nxt_st.redir_pc = vec_rsp_data;
          end
        end
      end
      default: begin
        nxt_st.fst = FS_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff       <= '0;
      st_ff.priv  <= RST_PRIV;
      st_ff.mtvec <= RST_MTVEC;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign irq_ack             = st_ff.ack;
  assign redirect_valid      = st_ff.redir_v;
  assign redirect_pc         = st_ff.redir_pc;
  assign vec_req             = st_ff.vreq;
  assign vec_addr            = st_ff.vaddr;
  assign iaf_exc             = st_ff.iaf;
  assign priv_mode           = st_ff.priv;
  assign machine_submode_now = st_ff.subm_now;
  assign active_int_level    = st_ff.act_lvl;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_vec_take;
    ce && take && irq_shv;
  endsequence
  sequence s_vec_ok;
    ce && vec_req && vec_rsp_valid && !vec_rsp_err;
  endsequence

  chk_take_onecycle: assert property (
    ce && take |=> irq_ack && mepc_q == $past(cur_pc) && priv_mode == PRIV_M
                   && machine_submode_now == SUBM_INT)
    else $error("entry effects not on one edge");
  chk_vec_first: assert property (
    s_vec_take |=> vec_req && !redirect_valid && st_ff.minhv)
    else $error("vectored entry branched before table read");
  chk_vec_target: assert property (
    s_vec_ok |=> redirect_valid && redirect_pc == $past(vec_rsp_data) && !st_ff.minhv)
    else $error("vectored branch target wrong");
  chk_vec_fault: assert property (
    ce && vec_req && vec_rsp_valid && vec_rsp_err |=> iaf_exc && st_ff.minhv && !redirect_valid)
    else $error("table fault handling wrong");
  chk_common_base: assert property (
    ce && take && !irq_shv |=> redirect_valid && redirect_pc[MTVEC_ALIGN-1:0] == 6'h00
                              && redirect_pc[31:MTVEC_ALIGN] == $past(st_ff.mtvec[31:MTVEC_ALIGN]))
    else $error("common base target wrong");
  chk_enable_save: assert property (
    ce && take |=> !st_ff.mstatus[MIE_BIT] && st_ff.mstatus[MPIE_BIT] == $past(st_ff.mstatus[MIE_BIT]))
    else $error("enable not saved and cleared");
  chk_level_save: assert property (
    ce && take |=> st_ff.prior_int_level == $past(st_ff.act_lvl) && active_int_level == $past(irq_level))
    else $error("level not saved on entry");
  chk_submode_save: assert property (
    ce && take |=> st_ff.machine_submode_prior == $past(st_ff.subm_now))
    else $error("sub-mode not saved on entry");
  chk_nested_level: assert property (
    ce && st_ff.act_lvl != 8'h00 && irq_level <= st_ff.act_lvl |=> !irq_ack)
    else $error("interrupt taken without higher level");
  chk_return_path: assert property (
    ce && mret_req && st_ff.fst == FS_IDLE && loc_mode |=> redirect_valid
      && redirect_pc == $past(st_ff.mepc) && active_int_level == $past(st_ff.prior_int_level))
    else $error("return did not restore level and PC");

  assign mepc_q = st_ff.mepc;
endmodule : cie_int_entry

// >>> cie_ctl_model.sv
// Behavioural local interrupt controller with its vector table memory.
// Assumes the bench raises sources through the raise task on one clock.
module cie_ctl_model #(parameter int DLY = 30) (
  input  wire logic        aclk,
  input  wire logic        irq_ack,
  input  wire logic        vec_req,
  input  wire logic [31:0] vec_addr,
  output logic             irq_valid,
  output logic [11:0]      irq_id,
  output logic [7:0]       irq_level,
  output logic             irq_shv,
  output logic             vec_rsp_valid,
  output logic [31:0]      vec_rsp_data,
  output logic             vec_rsp_err
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] pend = 4'h0;
  logic [3:0] shv  = 4'h0;
  logic [7:0] lvl [4];
  int         cnt  = 0;
  // Bench raises this to make every following table read fault
  logic       err_mode = 1'b0;
  // Highest pending level wins; nothing offered shows a junk pattern
  always_comb begin
    irq_valid = 1'b0;
    irq_id    = 12'hfff;
    irq_level = 8'hff;
    irq_shv   = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (pend[i] && (!irq_valid || lvl[i] > irq_level)) begin
        irq_valid = 1'b1;
        irq_id    = 12'(i);
        irq_level = lvl[i];
        irq_shv   = shv[i];
      end
    end
  end
  always @(posedge aclk) begin
    if (irq_ack) pend[irq_id[1:0]] <= 1'b0;
    vec_rsp_valid <= 1'b0;
    cnt <= vec_req ? cnt + 1 : 0;
    if (vec_req && cnt == DLY) begin
      vec_rsp_valid <= 1'b1;
      cnt <= 0;
    end
  end
  // Table word holds handler = entry address + 0x1000
  assign vec_rsp_data = vec_rsp_valid ? vec_addr + 32'h0000_1000 : ~vec_addr;
  assign vec_rsp_err  = vec_rsp_valid && err_mode;
  task automatic raise(input int i, input logic [7:0] l, input logic s);
    pend[i] <= 1'b1;
    lvl[i]  <= l;
    shv[i]  <= s;
  endtask : raise
endmodule : cie_ctl_model

// >>> tb_top.sv
// Bench for the interrupt entry block: AXI4-Lite tasks and entry/return tests.
// Assumes the controller model answers table reads after a long delay.
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  import cie_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 0, aresetn = 0, ce = 1, mret_req = 0, irq_ack, irq_valid, irq_shv;
  logic s_axil_awvalid = 0, s_axil_wvalid = 0, s_axil_arvalid = 0;
  logic s_axil_bready = 1, s_axil_rready = 1, s_axil_awready, s_axil_wready;
  logic s_axil_bvalid, s_axil_arready, s_axil_rvalid, redirect_valid, vec_req;
  logic vec_rsp_valid, vec_rsp_err, iaf_exc;
  logic [7:0] s_axil_awaddr = 0, s_axil_araddr = 0, irq_level, active_int_level;
  logic [31:0] s_axil_wdata = 0, s_axil_rdata, cur_pc = 32'h0000_1230;
  logic [31:0] redirect_pc, vec_addr, vec_rsp_data, d;
  logic [3:0] s_axil_wstrb = 4'hf;
  logic [1:0] s_axil_bresp, s_axil_rresp, priv_mode, machine_submode_now, r;
  logic [11:0] irq_id;
  int n_errors = 0, cmp_count = 0;
  cie_int_entry DUT (.aclk, .aresetn, .ce, .s_axil_awaddr, .s_axil_awvalid,
    .s_axil_awready, .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid, .s_axil_wready,
    .s_axil_bresp, .s_axil_bvalid, .s_axil_bready, .s_axil_araddr, .s_axil_arvalid,
    .s_axil_arready, .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid, .s_axil_rready,
    .irq_valid, .irq_id, .irq_level, .irq_shv, .irq_ack, .cur_pc, .mret_req,
    .redirect_valid, .redirect_pc, .vec_req, .vec_addr, .vec_rsp_valid, .vec_rsp_data,
    .vec_rsp_err, .iaf_exc, .priv_mode, .machine_submode_now, .active_int_level);
  cie_ctl_model #(.DLY(30)) ctl (.aclk, .irq_ack, .vec_req, .vec_addr, .irq_valid,
    .irq_id, .irq_level, .irq_shv, .vec_rsp_valid, .vec_rsp_data, .vec_rsp_err);
  always #5 aclk = ~aclk;
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    s_axil_awaddr <= a; s_axil_wdata <= v; s_axil_awvalid <= 1; s_axil_wvalid <= 1;
    forever begin
      @(posedge aclk);
      if (s_axil_awready) s_axil_awvalid <= 0;
      if (s_axil_wready) s_axil_wvalid <= 0;
      if (s_axil_bvalid) begin r = s_axil_bresp; break; end
    end
  endtask : axw
  task automatic axr(input logic [7:0] a);
    s_axil_araddr <= a; s_axil_arvalid <= 1;
    forever begin
      @(posedge aclk);
      if (s_axil_arready) s_axil_arvalid <= 0;
      if (s_axil_rvalid) begin d = s_axil_rdata; r = s_axil_rresp; break; end
    end
  endtask : axr
  // Waits up to 100 edges for redirect_valid or vec_req
  task automatic wait_sig(input bit vec);
    for (int n = 0; n < 100; n++) begin
      @(posedge aclk);
      if ((vec ? vec_req : redirect_valid) === 1'b1) break;
    end
  endtask : wait_sig
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  initial begin
    repeat (5000) @(posedge aclk);
    n_errors++;
    test_done;
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    axr(OFF_MTVEC); `CHK(d, RST_MTVEC)
    axr(8'h20); `CHK(r, RESP_SLVERR)
    axw(8'h20, 32'h0000_0001); `CHK(r, RESP_SLVERR)
    axw(OFF_MEPC, 32'h0000_5554); `CHK(r, RESP_OKAY)
    axr(OFF_MEPC); `CHK(d, 32'h0000_5554)
    axw(OFF_MTVEC, 32'h0000_0403); axw(OFF_MTVT, 32'h0000_0800);
    axw(OFF_MSTATUS, 32'h0000_0008);
    ctl.raise(0, 8'h0a, 0);
    wait_sig(0); `CHK(redirect_pc, 32'h0000_0400)
    `CHK(irq_ack, 1'b1)
    `CHK(priv_mode, PRIV_M)
    `CHK(machine_submode_now, SUBM_INT)
    `CHK(active_int_level, 8'h0a)
    axr(OFF_MEPC); `CHK(d, 32'h0000_1230)
    axr(OFF_MCAUSE); `CHK(d, 32'hb800_0000)
    axr(OFF_MSTATUS); `CHK(d, 32'h0000_1880)
    axw(OFF_MSTATUS, 32'h0000_1888); cur_pc <= 32'h0000_2460;
    ctl.raise(1, 8'h0a, 0);
    repeat (20) @(posedge aclk); `CHK(active_int_level, 8'h0a)
    axr(OFF_MEPC); `CHK(d, 32'h0000_1230)
    ctl.raise(3, 8'h14, 1);
    wait_sig(1); `CHK(vec_addr, 32'h0000_080c)
    `CHK(redirect_valid, 1'b0)
    axr(OFF_MCAUSE); `CHK(d[30], 1'b1)
    wait_sig(0); `CHK(redirect_pc, 32'h0000_180c)
    axr(OFF_MCAUSE); `CHK(d[30], 1'b0)
    `CHK(d[23:0], 24'h0a_0003)
    `CHK(active_int_level, 8'h14)
    mret_req <= 1; @(posedge aclk); mret_req <= 0;
    wait_sig(0); `CHK(redirect_pc, 32'h0000_2460)
    `CHK(active_int_level, 8'h0a)
    `CHK(machine_submode_now, SUBM_INT)
    axr(OFF_MSTATUS); `CHK(d[MIE_BIT], 1'b1)
    `CHK(priv_mode, PRIV_M)
    // Prior level 0 lets the waiting equal-level source in after the next return
    axw(OFF_MCAUSE, 32'h0800_0000);
    mret_req <= 1; @(posedge aclk); mret_req <= 0;
    wait_sig(0); `CHK(priv_mode, PRIV_U)
    `CHK(active_int_level, 8'h00)
    wait_sig(0); `CHK(redirect_pc, 32'h0000_0400)
    `CHK(priv_mode, PRIV_M)
    axr(OFF_MSTATUS); `CHK(d, 32'h0000_0080)
    axr(OFF_MCAUSE); `CHK(d, 32'h8800_0001)
    axw(OFF_MSTATUS, 32'h0000_0008); ctl.err_mode <= 1'b1;
    ctl.raise(2, 8'h1e, 1);
    wait_sig(1); `CHK(vec_addr, 32'h0000_0808)
    do @(posedge aclk); while (vec_req === 1'b1);
    `CHK(iaf_exc, 1'b1)
    `CHK(redirect_valid, 1'b0)
    axr(OFF_MCAUSE); `CHK(d[30], 1'b1)
    test_done;
  end
endmodule : tb_top
